//--- common/audio_pin_pkg.sv
// package: register map, field positions and reset values for the
// frame-sync / bit-clock pin logic of the multichannel audio port.
// assumes a 32-bit apb slave with byte addresses on word boundaries.
package audio_pin_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TX_CLOCK_CONTROL_REG = 8'h00;
  localparam logic [7:0] ADDR_RX_CLOCK_CONTROL_REG = 8'h04;
  localparam logic [7:0] ADDR_COMMON_CONTROL_REG = 8'h08;
  localparam logic [7:0] ADDR_COMMON_STATUS_REG = 8'h0c;
  localparam logic [7:0] ADDR_PORT_MODE_REG = 8'h10;
  localparam logic [7:0] ADDR_PORT_DATA_REG = 8'h14;
  localparam logic [7:0] ADDR_FRAME_CFG_REG = 8'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TX_FSYNC_DIRECTION_BIT = 0;
  localparam int RX_CLOCK_DIRECTION_BIT = 0;
  localparam int SYNC_MODE_SELECT_BIT = 0;
  localparam int OUT_FLAG_ZERO_BIT = 1;
  localparam int NETWORK_MODE_BIT = 2;
  localparam int IN_FLAG_ZERO_BIT = 0;
  localparam int STAT_FS_LEVEL_BIT = 1;
  localparam int STAT_CK_LEVEL_BIT = 2;
  localparam int PORT_BIT_FOUR_LSB = 0;
  localparam int PORT_BIT_ZERO_LSB = 2;
  localparam int DATA_BIT_FOUR = 0;
  localparam int DATA_BIT_ZERO = 1;
  localparam int SLOT_LAST_LSB = 0;
  localparam int SLOTS_LAST_LSB = 8;

  // ----------------------------------------------------------------
  // pin modes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] PIN_OFF = 2'h0;
  localparam logic [1:0] PIN_IN = 2'h1;
  localparam logic [1:0] PIN_OUT = 2'h2;
  localparam logic [1:0] PIN_SERIAL = 2'h3;
  localparam logic [3:0] PORT_MODE_RESET = 4'h0;
  localparam logic [4:0] SLOT_LAST_RESET = 5'h1f;
  localparam logic [3:0] SLOTS_LAST_RESET = 4'h1;

endpackage

//--- core/bit_sync.sv
// two-flop synchroniser for a vector of independent levels.
// assumes each bit is quasi-static or a level; no word coherence.
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  if (WIDTH < 1)
  begin : g_bad
    $error("bit_sync width must be at least one");
  end

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule
`default_nettype wire

//--- core/frame_timer.sv
// bit / slot / frame counter on the serial bit clock.
// assumes restart is a one-cycle pulse already in this clock domain.
`timescale 1ns/1ps
`default_nettype none
module frame_timer #(
  parameter int SLOT_W = 5,
  parameter int SLOTS_W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [SLOT_W-1:0] slot_last,
  input wire logic [SLOTS_W-1:0] slots_last,
  input wire logic use_ext,
  input wire logic restart,
  output logic frame_start_q,
  output logic slot_start_q
);

  if (SLOT_W < 1 || SLOTS_W < 1)
  begin : g_bad
    $error("frame_timer counter widths must be at least one");
  end

  logic [SLOT_W-1:0] bit_q;
  logic [SLOTS_W-1:0] slot_q;
  logic slot_end;
  logic frame_end;

  assign slot_end = (bit_q == slot_last);
  assign frame_end = slot_end && (slot_q == slots_last);

  // external sync realigns; otherwise the frame runs free
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_q <= '0;
      slot_q <= '0;
      frame_start_q <= 1'b0;
      slot_start_q <= 1'b0;
    end
    else if ((use_ext && restart) || (!use_ext && frame_end))
    begin
      bit_q <= '0;
      slot_q <= '0;
      frame_start_q <= 1'b1;
      slot_start_q <= 1'b1;
    end
    else if (slot_end)
    begin
      bit_q <= '0;
      slot_q <= frame_end ? '0 : slot_q + 1'b1;
      frame_start_q <= 1'b0;
      slot_start_q <= 1'b1;
    end
    else
    begin
      bit_q <= bit_q + 1'b1;
      frame_start_q <= 1'b0;
      slot_start_q <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- core/audio_sync_flag_pins.sv
// pin logic for the transmit frame-sync pin and the receive bit-clock
// pin of the multichannel audio port, with an apb register slave.
// assumes tx_bit_clock_pin is the running serial bit clock of the link.
//
// Summary of operation
// - sync mode: transmit frame-sync pin frames both transmitters and receivers.
// - async mode: transmit frame-sync pin frames transmitters only.
// - frame-sync pin drives or senses per the tx frame-sync direction bit.
// - as port bits each pin is input, output or disconnected.
// - after reset both pins are disconnected port bits, not driving.
// - async mode: receive bit-clock pin is the receiver clock, in or out.
// - sync mode: receive bit-clock pin becomes flag zero, not a clock.
// - flag zero direction follows the rx clock direction bit.
// - output flag zero shows the control register flag bit.
// - output flag updates on frame sync, or each slot in network mode.
// - input flag zero is captured into the status register.
// - input flag capture timed by frame sync, or each slot in network.
// - tx bit clock clocks receivers too in sync mode, else transmitters only.
`timescale 1ns/1ps
`default_nettype none
module audio_sync_flag_pins
  import audio_pin_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_bit_clock_pin,
  input wire logic tx_frame_sync_pin_i,
  output logic tx_frame_sync_pin_o,
  output logic tx_frame_sync_pin_oe,
  input wire logic rx_bit_clock_pin_i,
  output logic rx_bit_clock_pin_o,
  output logic rx_bit_clock_pin_oe,
  output logic tx_fsync,
  output logic rx_fsync,
  output logic rx_clk_from_tx,
  output logic rx_ext_clk
);

  // ----------------------------------------------------------------
  // apb registers
  // ----------------------------------------------------------------
  logic tx_fsync_direction_q;
  logic rx_clock_direction_q;
  logic sync_mode_select_q;
  logic out_flag_zero_q;
  logic network_mode_q;
  logic [3:0] port_mode_q;
  logic [1:0] port_data_q;
  logic [4:0] slot_last_q;
  logic [3:0] slots_last_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic setup;
  logic wr_en;
  logic mapped;
  logic [1:0] pin_lvl_p;
  logic in_flag_p;
  logic [1:0] gpio_in;
  logic [31:0] rd_d;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;

  // address decode
  always_comb
  begin
    mapped = 1'b1;
    rd_d = 32'h0;
    case (paddr)
      ADDR_TX_CLOCK_CONTROL_REG: rd_d[TX_FSYNC_DIRECTION_BIT] = tx_fsync_direction_q;
      ADDR_RX_CLOCK_CONTROL_REG: rd_d[RX_CLOCK_DIRECTION_BIT] = rx_clock_direction_q;
      ADDR_COMMON_CONTROL_REG:
      begin
        rd_d[SYNC_MODE_SELECT_BIT] = sync_mode_select_q;
        rd_d[OUT_FLAG_ZERO_BIT] = out_flag_zero_q;
        rd_d[NETWORK_MODE_BIT] = network_mode_q;
      end
      ADDR_COMMON_STATUS_REG:
      begin
        rd_d[IN_FLAG_ZERO_BIT] = in_flag_p;
        rd_d[STAT_FS_LEVEL_BIT] = gpio_in[0];
        rd_d[STAT_CK_LEVEL_BIT] = gpio_in[1];
      end
      ADDR_PORT_MODE_REG: rd_d[3:0] = port_mode_q;
      ADDR_PORT_DATA_REG: rd_d[1:0] = gpio_in;
      ADDR_FRAME_CFG_REG:
      begin
        rd_d[SLOT_LAST_LSB +: 5] = slot_last_q;
        rd_d[SLOTS_LAST_LSB +: 4] = slots_last_q;
      end
      default: mapped = 1'b0;
    endcase
  end

  // no wait state: answer registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end
    else
    begin
      pready_q <= setup;
      pslverr_q <= setup && !mapped;
      if (setup)
        prdata_q <= pwrite ? 32'h0 : rd_d;
    end
  end

  logic cfg_tog_q;

  // write toggle tells the link side when to reload the whole word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_tog_q <= 1'b0;
    else if (wr_en)
      cfg_tog_q <= !cfg_tog_q;
  end

  // control register writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_fsync_direction_q <= 1'b0;
      rx_clock_direction_q <= 1'b0;
      sync_mode_select_q <= 1'b0;
      out_flag_zero_q <= 1'b0;
      network_mode_q <= 1'b0;
      port_mode_q <= PORT_MODE_RESET;
      port_data_q <= 2'h0;
      slot_last_q <= SLOT_LAST_RESET;
      slots_last_q <= SLOTS_LAST_RESET;
    end
    else if (wr_en)
    begin
      case (paddr)
        ADDR_TX_CLOCK_CONTROL_REG:
          tx_fsync_direction_q <= pwdata[TX_FSYNC_DIRECTION_BIT];
        ADDR_RX_CLOCK_CONTROL_REG:
          rx_clock_direction_q <= pwdata[RX_CLOCK_DIRECTION_BIT];
        ADDR_COMMON_CONTROL_REG:
        begin
          sync_mode_select_q <= pwdata[SYNC_MODE_SELECT_BIT];
          out_flag_zero_q <= pwdata[OUT_FLAG_ZERO_BIT];
          network_mode_q <= pwdata[NETWORK_MODE_BIT];
        end
        ADDR_PORT_MODE_REG: port_mode_q <= pwdata[3:0];
        ADDR_PORT_DATA_REG: port_data_q <= pwdata[1:0];
        ADDR_FRAME_CFG_REG:
        begin
          slot_last_q <= pwdata[SLOT_LAST_LSB +: 5];
          slots_last_q <= pwdata[SLOTS_LAST_LSB +: 4];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin levels and flag back into pclk
  // ----------------------------------------------------------------
  logic in_flag_q;

  bit_sync #(.WIDTH(3)) u_sync_p (
    .clk(pclk),
    .rst_n(presetn),
    .d({in_flag_q, rx_bit_clock_pin_i, tx_frame_sync_pin_i}),
    .q({in_flag_p, pin_lvl_p})
  );

  // port bit reads: only an input pin shows its level
  always_comb
  begin
    gpio_in[0] = (port_mode_q[PORT_BIT_FOUR_LSB +: 2] == PIN_IN) && pin_lvl_p[0];
    gpio_in[1] = (port_mode_q[PORT_BIT_ZERO_LSB +: 2] == PIN_IN) && pin_lvl_p[1];
  end

  // ----------------------------------------------------------------
  // link domain: configuration and pins on the bit clock
  // ----------------------------------------------------------------
  logic [1:0] lrst_q;
  logic lrst_n;
  logic [19:0] cfg_l;
  logic [1:0] pin_l;
  logic c_fsd;
  logic c_ckd;
  logic c_sync;
  logic c_net;
  logic c_oflag;
  logic [1:0] c_fs_mode;
  logic [1:0] c_ck_mode;
  logic [1:0] c_pdata;
  logic fs_ser;
  logic ck_ser;
  logic flag_out;
  logic flag_in;
  logic strobe;
  logic fs_prev_q;
  logic frame_start;
  logic slot_start;
  logic fs_o_q;
  logic fs_oe_q;
  logic ck_o_q;
  logic ck_oe_q;
  logic tx_fsync_q;
  logic rx_fsync_q;
  logic rx_from_tx_q;
  logic rx_ext_q;
  logic rx_div_q;

  // reset release aligned to the bit clock
  always_ff @(posedge tx_bit_clock_pin or negedge presetn)
  begin
    if (!presetn)
      lrst_q <= 2'b00;
    else
      lrst_q <= {lrst_q[0], 1'b1};
  end
  assign lrst_n = lrst_q[1];

  logic cfg_tog_l;
  logic cfg_tog_seen_q;

  bit_sync #(.WIDTH(1)) u_sync_cfg (
    .clk(tx_bit_clock_pin),
    .rst_n(lrst_n),
    .d(cfg_tog_q),
    .q(cfg_tog_l)
  );

  // whole word reloads after the toggle arrives: no torn multi-bit fields
  always_ff @(posedge tx_bit_clock_pin or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      cfg_tog_seen_q <= 1'b0;
      cfg_l <= {SLOTS_LAST_RESET, SLOT_LAST_RESET, 2'h0, PORT_MODE_RESET, 5'h00};
    end
    else
    begin
      cfg_tog_seen_q <= cfg_tog_l;
      if (cfg_tog_l != cfg_tog_seen_q)
        cfg_l <= {slots_last_q, slot_last_q, port_data_q, port_mode_q, out_flag_zero_q,
                  network_mode_q, sync_mode_select_q, rx_clock_direction_q,
                  tx_fsync_direction_q};
    end
  end

  bit_sync #(.WIDTH(2)) u_sync_pin (
    .clk(tx_bit_clock_pin),
    .rst_n(lrst_n),
    .d({rx_bit_clock_pin_i, tx_frame_sync_pin_i}),
    .q(pin_l)
  );

  assign c_fsd = cfg_l[0];
  assign c_ckd = cfg_l[1];
  assign c_sync = cfg_l[2];
  assign c_net = cfg_l[3];
  assign c_oflag = cfg_l[4];
  assign c_fs_mode = cfg_l[5 + PORT_BIT_FOUR_LSB +: 2];
  assign c_ck_mode = cfg_l[5 + PORT_BIT_ZERO_LSB +: 2];
  assign c_pdata = cfg_l[10:9];
  assign fs_ser = (c_fs_mode == PIN_SERIAL);
  assign ck_ser = (c_ck_mode == PIN_SERIAL);
  assign flag_out = ck_ser && c_sync && c_ckd;
  assign flag_in = ck_ser && c_sync && !c_ckd;
  assign strobe = c_net ? slot_start : frame_start;

  // frame edge detect on the sensed sync, ignored unless serial
  always_ff @(posedge tx_bit_clock_pin or negedge lrst_n)
  begin
    if (!lrst_n)
      fs_prev_q <= 1'b0;
    else
      fs_prev_q <= fs_ser && pin_l[0];
  end

  frame_timer #(.SLOT_W(5), .SLOTS_W(4)) u_timer (
    .clk(tx_bit_clock_pin),
    .rst_n(lrst_n),
    .slot_last(cfg_l[15:11]),
    .slots_last(cfg_l[19:16]),
    .use_ext(!c_fsd),
    .restart(fs_ser && pin_l[0] && !fs_prev_q),
    .frame_start_q(frame_start),
    .slot_start_q(slot_start)
  );

  // frame-sync pin: port bit, generated sync out, or sensed sync
  always_ff @(posedge tx_bit_clock_pin or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      fs_o_q <= 1'b0;
      fs_oe_q <= 1'b0;
    end
    else
    begin
      fs_oe_q <= (c_fs_mode == PIN_OUT) || (fs_ser && c_fsd);
      fs_o_q <= (c_fs_mode == PIN_OUT) ? c_pdata[0] : (fs_ser && frame_start);
    end
  end

  // frame timing to transmitters and receivers
  always_ff @(posedge tx_bit_clock_pin or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      tx_fsync_q <= 1'b0;
      rx_fsync_q <= 1'b0;
    end
    else
    begin
      tx_fsync_q <= fs_ser && frame_start;
      rx_fsync_q <= c_sync && fs_ser && frame_start;
    end
  end

  // receive clock source
  always_ff @(posedge tx_bit_clock_pin or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      rx_from_tx_q <= 1'b0;
      rx_ext_q <= 1'b0;
      rx_div_q <= 1'b0;
    end
    else
    begin
      rx_from_tx_q <= c_sync;
      rx_ext_q <= !c_sync && ck_ser && !c_ckd && pin_l[1];
      rx_div_q <= (ck_ser && !c_sync && c_ckd) ? !rx_div_q : 1'b0;
    end
  end

  // bit-clock pin: port bit, receiver clock out, or output flag
  always_ff @(posedge tx_bit_clock_pin or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      ck_o_q <= 1'b0;
      ck_oe_q <= 1'b0;
    end
    else
    begin
      ck_oe_q <= (c_ck_mode == PIN_OUT) || (ck_ser && c_ckd);
      if (c_ck_mode == PIN_OUT)
        ck_o_q <= c_pdata[1];
      else if (flag_out)
        ck_o_q <= strobe ? c_oflag : ck_o_q;
      else
        ck_o_q <= ck_ser && c_ckd && !rx_div_q;
    end
  end

  // input flag sampled at frame or slot start
  always_ff @(posedge tx_bit_clock_pin or negedge lrst_n)
  begin
    if (!lrst_n)
      in_flag_q <= 1'b0;
    else if (flag_in && strobe)
      in_flag_q <= pin_l[1];
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign tx_frame_sync_pin_o = fs_o_q;
  assign tx_frame_sync_pin_oe = fs_oe_q;
  assign rx_bit_clock_pin_o = ck_o_q;
  assign rx_bit_clock_pin_oe = ck_oe_q;
  assign tx_fsync = tx_fsync_q;
  assign rx_fsync = rx_fsync_q;
  assign rx_clk_from_tx = rx_from_tx_q;
  assign rx_ext_clk = rx_ext_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_fs_drive_dir: assert property (@(posedge tx_bit_clock_pin) disable iff (!lrst_n)
    (fs_ser && c_fsd) |=> fs_oe_q)
    else $error("frame-sync pin not driven in output direction");

  chk_rx_fs_async: assert property (@(posedge tx_bit_clock_pin) disable iff (!lrst_n)
    !c_sync |=> !rx_fsync_q)
    else $error("receivers framed by tx sync in async mode");

  chk_rx_fs_sync: assert property (@(posedge tx_bit_clock_pin) disable iff (!lrst_n)
    (c_sync && fs_ser && frame_start) |=> (rx_fsync_q && tx_fsync_q))
    else $error("receivers missed frame sync in sync mode");

  chk_off_no_drive: assert property (@(posedge tx_bit_clock_pin) disable iff (!lrst_n)
    (c_ck_mode == PIN_OFF && c_fs_mode == PIN_OFF) |=> (!ck_oe_q && !fs_oe_q))
    else $error("disconnected pin is driving");

  chk_oflag_update: assert property (@(posedge tx_bit_clock_pin) disable iff (!lrst_n)
    (flag_out && strobe) |=> (ck_o_q == $past(c_oflag) && ck_oe_q))
    else $error("output flag not presented at strobe");

  chk_oflag_hold: assert property (@(posedge tx_bit_clock_pin) disable iff (!lrst_n)
    (flag_out && !strobe) ##1 flag_out |-> $stable(ck_o_q))
    else $error("output flag changed between strobes");

  chk_iflag_capture: assert property (@(posedge tx_bit_clock_pin) disable iff (!lrst_n)
    (flag_in && strobe) |=> (in_flag_q == $past(pin_l[1])))
    else $error("input flag not captured at strobe");

  chk_rx_clk_src: assert property (@(posedge tx_bit_clock_pin) disable iff (!lrst_n)
    c_sync |=> (rx_from_tx_q && !rx_ext_q))
    else $error("receiver clock source wrong in sync mode");

  chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !mapped) |=> (pready_q && pslverr_q))
    else $error("unmapped access not answered with error");

  chk_reset_off: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (port_mode_q == PORT_MODE_RESET))
    else $error("port mode not disconnected after reset");

  cov_oflag_net: cover property (@(posedge tx_bit_clock_pin) disable iff (!lrst_n)
    flag_out && c_net && slot_start && !frame_start);

  cov_iflag_frame: cover property (@(posedge tx_bit_clock_pin) disable iff (!lrst_n)
    flag_in && !c_net && frame_start);

  cov_apb_write: cover property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == ADDR_COMMON_CONTROL_REG);

endmodule
`default_nettype wire

//--- verification/codec_model.sv
// codec model: makes the bit clock, frame pulses and the flag level.
// assumes pull-downs on both pins: a line nobody drives reads 0.
`timescale 1ns/1ps
`default_nettype none
module codec_model (
  input wire logic [1:0] fs_ctl,
  input wire logic ck_drive,
  input wire logic ck_val,
  input wire logic fs_o,
  input wire logic fs_oe,
  input wire logic ck_o,
  input wire logic ck_oe,
  output logic bit_clk,
  output logic fs_wire,
  output logic ck_wire
);
  // ----------------------------------------------------------------
  // bit clock and frame pulses
  // ----------------------------------------------------------------
  logic [4:0] cnt_q = 5'h00;

  // bit clock runs on across frames, 12 ns, offset from pclk
  initial
  begin
    bit_clk = 1'b0;
    #3;
    forever #6 bit_clk = ~bit_clk;
  end

  // one pulse every 32 bit clocks
  always_ff @(posedge bit_clk)
  begin
    cnt_q <= cnt_q + 5'h01;
  end

  // ----------------------------------------------------------------
  // wire levels
  // ----------------------------------------------------------------
  // device drive first, then codec (0 off, 1 high, 2 pulses), else pull-down
  assign fs_wire = fs_oe ? fs_o : ((fs_ctl == 2'h1) | ((fs_ctl == 2'h2) & (cnt_q == 5'h00)));
  assign ck_wire = ck_oe ? ck_o : (ck_drive & ck_val);
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the audio sync and flag pin logic.
// assumes codec_model supplies the bit clock and the pin levels.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import audio_pin_pkg::*;
;
  typedef struct {
    logic [3:0] mode;
    logic [1:0] dirs;
    logic [2:0] ctrl;
    logic [1:0] data;
    logic [4:0] exp;
  } row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic lclk, fs_wire, ck_wire, fs_o, fs_oe, ck_o, ck_oe;
  logic tx_fsync, rx_fsync, rxtx, rx_ext_clk;
  logic [1:0] fs_ctl = 2'h0;
  logic ck_drive = 1'b0;
  logic ck_val = 1'b0;
  logic [31:0] rd;
  logic er;
  logic [4:0] m;
  int num_errors = 0;
  int cmp_count = 0;
  int lcnt = 0;
  int n_tx = 0;
  int n_rx = 0;
  int s, a, b;
  // mode, {rx dir, tx dir}, {net, flag, sync}, port data, {fs oe, ck oe, fs o, ck o, rxtx}
  row_t rows [8] = '{
    '{4'h0, 2'h3, 3'h0, 2'h3, 5'h00},
    '{4'ha, 2'h0, 3'h0, 2'h1, 5'h1c},
    '{4'ha, 2'h0, 3'h0, 2'h2, 5'h1a},
    '{4'h5, 2'h3, 3'h0, 2'h3, 5'h00},
    '{4'hf, 2'h3, 3'h1, 2'h0, 5'h19},
    '{4'hf, 2'h0, 3'h0, 2'h0, 5'h00},
    '{4'hf, 2'h3, 3'h0, 2'h0, 5'h18},
    '{4'hf, 2'h0, 3'h1, 2'h0, 5'h01}
  };

  // ----------------------------------------------------------------
  // clock, design and codec
  // ----------------------------------------------------------------
  always #20 pclk = ~pclk;

  audio_sync_flag_pins dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_bit_clock_pin(lclk), .tx_frame_sync_pin_i(fs_wire), .tx_frame_sync_pin_o(fs_o),
    .tx_frame_sync_pin_oe(fs_oe), .rx_bit_clock_pin_i(ck_wire), .rx_bit_clock_pin_o(ck_o),
    .rx_bit_clock_pin_oe(ck_oe), .tx_fsync(tx_fsync), .rx_fsync(rx_fsync),
    .rx_clk_from_tx(rxtx), .rx_ext_clk(rx_ext_clk)
  );

  codec_model codec (
    .fs_ctl(fs_ctl), .ck_drive(ck_drive), .ck_val(ck_val), .fs_o(fs_o), .fs_oe(fs_oe),
    .ck_o(ck_o), .ck_oe(ck_oe), .bit_clk(lclk), .fs_wire(fs_wire), .ck_wire(ck_wire)
  );

  // link cycle and frame pulse counts
  always @(posedge lclk)
  begin
    lcnt <= lcnt + 1;
    n_tx <= n_tx + (tx_fsync === 1'b1);
    n_rx <= n_rx + (rx_fsync === 1'b1);
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      num_errors++;
    end
  endtask

  task tally_and_finish;
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // one apb transfer; waits for pready under a bound
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
      num_errors++;
  endtask

  task setup(input logic [3:0] mode, input logic [1:0] dirs, input logic [2:0] ctrl);
    apb(1'b1, ADDR_TX_CLOCK_CONTROL_REG, {31'h0, dirs[0]}, rd, er);
    apb(1'b1, ADDR_RX_CLOCK_CONTROL_REG, {31'h0, dirs[1]}, rd, er);
    apb(1'b1, ADDR_COMMON_CONTROL_REG, {29'h0, ctrl}, rd, er);
    apb(1'b1, ADDR_PORT_MODE_REG, {28'h0, mode}, rd, er);
  endtask

  // returns at the link edge that samples a frame pulse
  task wait_fs;
    int n;
    n = 0;
    do
    begin
      @(posedge lclk);
      n++;
    end
    while (tx_fsync !== 1'b1 && n < 100);
    check({31'h0, tx_fsync}, 32'h1);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check({30'h0, fs_oe, ck_oe}, 32'h0);
    apb(1'b0, ADDR_PORT_MODE_REG, 32'h0, rd, er);
    check(rd, 32'h0);
    apb(1'b0, ADDR_FRAME_CFG_REG, 32'h0, rd, er);
    check(rd, 32'h0000011f);
    apb(1'b0, 8'h1c, 32'h0, rd, er);
    check({rd[30:0], er}, 32'h1);
    apb(1'b1, ADDR_FRAME_CFG_REG, 32'h00000307, rd, er);
    $display("done: reset and map");
    foreach (rows[i])
    begin
      apb(1'b1, ADDR_PORT_DATA_REG, {30'h0, rows[i].data}, rd, er);
      setup(rows[i].mode, rows[i].dirs, rows[i].ctrl);
      repeat (8) @(posedge lclk);
      m = (rows[i].mode == 4'ha) ? 5'h1f : 5'h13;
      check({27'h0, m & {fs_oe, ck_oe, fs_o, ck_o, rxtx}}, {27'h0, m & rows[i].exp});
    end
    $display("done: pin modes");
    // frame pulses: generated or sensed, sync or async
    for (int k = 0; k < 4; k++)
    begin
      fs_ctl <= k[1] ? 2'h2 : 2'h0;
      setup(4'hf, {1'b0, ~k[1]}, {2'h0, k[0]});
      repeat (40) @(posedge lclk);
      a = n_tx;
      b = n_rx;
      repeat (64) @(posedge lclk);
      check(n_tx - a, 32'h2);
      check(n_rx - b, k[0] ? 32'h2 : 32'h0);
      check({31'h0, rxtx}, {31'h0, k[0]});
    end
    fs_ctl <= 2'h0;
    $display("done: frame sync");
    // async receiver clock as input follows the pin
    ck_drive <= 1'b1;
    ck_val <= 1'b1;
    setup(4'hf, 2'h1, 3'h0);
    repeat (8) @(posedge lclk);
    check({31'h0, rx_ext_clk}, 32'h1);
    ck_drive <= 1'b0;
    // output flag: frame aligned, or slot aligned in network mode
    for (int net = 0; net < 2; net++)
    begin
      setup(4'hf, 2'h3, {net[0], 2'h1});
      wait_fs;
      wait_fs;
      s = lcnt;
      apb(1'b1, ADDR_COMMON_CONTROL_REG, {29'h0, net[0], 2'h3}, rd, er);
      while (lcnt - s < 24)
        @(posedge lclk);
      check({31'h0, ck_o}, {31'h0, net[0]});
      wait_fs;
      repeat (3) @(posedge lclk);
      check({31'h0, ck_o}, 32'h1);
    end
    $display("done: output flag");
    // input flag captured only at frame sync
    ck_drive <= 1'b1;
    setup(4'hf, 2'h1, 3'h1);
    wait_fs;
    wait_fs;
    apb(1'b0, ADDR_COMMON_STATUS_REG, 32'h0, rd, er);
    check({31'h0, rd[IN_FLAG_ZERO_BIT]}, 32'h1);
    wait_fs;
    ck_val <= 1'b0;
    apb(1'b0, ADDR_COMMON_STATUS_REG, 32'h0, rd, er);
    check({31'h0, rd[IN_FLAG_ZERO_BIT]}, 32'h1);
    wait_fs;
    wait_fs;
    apb(1'b0, ADDR_COMMON_STATUS_REG, 32'h0, rd, er);
    check({31'h0, rd[IN_FLAG_ZERO_BIT]}, 32'h0);
    $display("done: input flag");
    // port inputs read back; disconnected pins read nothing
    fs_ctl <= 2'h1;
    ck_val <= 1'b1;
    setup(4'h5, 2'h0, 3'h0);
    repeat (8) @(posedge lclk);
    apb(1'b0, ADDR_PORT_DATA_REG, 32'h0, rd, er);
    check(rd, 32'h3);
    setup(4'h0, 2'h0, 3'h0);
    repeat (8) @(posedge lclk);
    apb(1'b0, ADDR_PORT_DATA_REG, 32'h0, rd, er);
    check(rd, 32'h0);
    check({30'h0, fs_oe, ck_oe}, 32'h0);
    $display("done: port inputs");
    tally_and_finish;
  end

  // watchdog, well beyond the expected run of about 22 us
  initial
  begin
    #400us;
    num_errors++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
